//--- hw/sfp_if.sv
// interface carrying the live settings from the register bank to the frame judge
interface sfp_if;
  logic       mc_use_map;
  logic       uc_use_map;
  logic       in_range_drop;
  logic       gap_drop;
  logic [8:0] preserve;
  logic [8:0] protect;
  logic [8:0] uni_map;
  logic [8:0] mc_map;
  modport bank (output mc_use_map, uc_use_map, in_range_drop, gap_drop,
                preserve, protect, uni_map, mc_map);
  modport judge (input mc_use_map, uc_use_map, in_range_drop, gap_drop,
                 preserve, protect, uni_map, mc_map);
endinterface

//--- hw/sfp_judge.sv
// frame judge: length checks, miss forwarding and port isolation for one frame request
module sfp_judge
  import sfp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  sfp_if.judge             cfg,
  input  wire logic        req,
  input  wire logic [3:0]  src,
  input  wire logic        miss,
  input  wire logic        mcast,
  input  wire logic        crc_ok,
  input  wire logic [15:0] len_type,
  input  wire logic [15:0] data_len,
  input  wire logic [8:0]  hit_map,
  output logic             done,
  output logic             drop,
  output logic [8:0]       dest,
  output logic             keep_format
);
  sfp_state_type state;
  logic [8:0]  src_bit;
  logic        in_err;
  logic        gap_err;
  logic [8:0]  base;
  logic [8:0]  iso;

  // one-hot of the ingress port
  assign src_bit = (src < 4'd9) ? (9'h_001 << src) : 9'h_000;

  // length checks, gap check only looks at the field value
  assign in_err = crc_ok && (((len_type >= SFP_LEN_MIN) && (len_type <= SFP_LEN_MAX)
                  && (len_type != data_len))
                  || ((len_type < SFP_LEN_MIN) && (data_len > SFP_LEN_MIN)));
  assign gap_err = crc_ok && (len_type > SFP_LEN_MAX) && (len_type < SFP_TYPE_MIN);

  // forward set before isolation: hit, map or flood
  always_comb
  begin
    if (!miss)
      base = hit_map;
    else if (mcast && cfg.mc_use_map)
      base = cfg.mc_map;
    else if (!mcast && cfg.uc_use_map)
      base = cfg.uni_map;
    else
      base = SFP_PORT_MASK & ~src_bit;
  end

  // protected ingress may not reach other protected ports
  assign iso = ((cfg.protect & src_bit) != 9'h_000) ? ~cfg.protect : 9'h_1ff;

  // request/answer sequencing, answer two cycles after request
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state <= SFP_IDLE;
    else
      case (state)
        SFP_IDLE:   state <= req ? SFP_JUDGE : SFP_IDLE;
        SFP_JUDGE:  state <= SFP_ANSWER;
        SFP_ANSWER: state <= SFP_IDLE;
        default:    state <= SFP_IDLE;
      endcase
  end

  // answer registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      done        <= 1'b0;
      drop        <= 1'b0;
      dest        <= 9'h_000;
      keep_format <= 1'b0;
    end
    else if (state == SFP_JUDGE)
    begin
      done        <= 1'b1;
      drop        <= (cfg.in_range_drop && in_err) || (cfg.gap_drop && gap_err)
                     || ((base & iso & SFP_PORT_MASK & ~src_bit) == 9'h_000);
      dest        <= base & iso & SFP_PORT_MASK & ~src_bit;
      keep_format <= (cfg.preserve & src_bit) != 9'h_000;
    end
    else
      done <= 1'b0;
  end
endmodule

//--- hw/sfp_pkg.sv
// package of register map, field positions and frame length limits for the forward policy bank
package sfp_pkg;
  // register offsets (byte addresses within the page)
  localparam logic [7:0] SFP_ADDR_FWD_CTRL   = 8'h21;
  localparam logic [7:0] SFP_ADDR_PRESERVE_L = 8'h22;
  localparam logic [7:0] SFP_ADDR_PRESERVE_H = 8'h23;
  localparam logic [7:0] SFP_ADDR_PROTECT_L  = 8'h24;
  localparam logic [7:0] SFP_ADDR_PROTECT_H  = 8'h25;
  localparam logic [7:0] SFP_ADDR_UNI_MAP_L  = 8'h32;
  localparam logic [7:0] SFP_ADDR_UNI_MAP_H  = 8'h33;
  localparam logic [7:0] SFP_ADDR_MC_MAP_L   = 8'h34;
  localparam logic [7:0] SFP_ADDR_MC_MAP_H   = 8'h35;
  // forward control field positions
  localparam int SFP_BIT_MC_MAP    = 7;
  localparam int SFP_BIT_UC_MAP    = 6;
  localparam int SFP_BIT_IN_RANGE  = 2;
  localparam int SFP_BIT_GAP       = 1;
  localparam int SFP_BIT_GRP_SCHEME = 0;
  // writable masks: reserved bits stay at their default
  localparam logic [7:0] SFP_FWD_CTRL_WMASK = 8'h_c6;
  localparam logic [7:0] SFP_FWD_CTRL_RESET = 8'h_01;
  localparam logic [8:0] SFP_PORT_MASK      = 9'h_13f;
  localparam logic [8:0] SFP_PORT_RESET     = 9'h_000;
  // frame length limits
  localparam logic [15:0] SFP_LEN_MIN      = 16'h_002e;
  localparam logic [15:0] SFP_LEN_MAX      = 16'h_05dc;
  localparam logic [15:0] SFP_TYPE_MIN     = 16'h_0600;
  // decision states of the frame judge
  typedef enum logic [2:0]
  {
    SFP_IDLE   = 3'b001,
    SFP_JUDGE  = 3'b010,
    SFP_ANSWER = 3'b100
  } sfp_state_type;
endpackage

//--- hw/sfp_regs.sv
// forward policy register bank with its frame judge
//
// Functional notes
// - multicast miss bit set forwards by multicast map, else floods.
// - unicast miss bit set forwards by unicast map, else floods.
// - in-range discard drops good frames whose length 46..1500 mismatches data count.
// - length below 46 with over 46 data octets is also an in-range error.
// - gap discard drops good frames with length field between 1500 and 1536.
// - gap discard judges only the field value, never the received length.
// - group address scheme bit resets to one; software never writes zero.
// - preserve field: bit 8 management port, bits 5..0 ports, 7..6 reserved.
// - preserving ingress ports leave all frames untouched by tag processing.
// - timestamp and management header handling still apply when preserving.
// - protected ports never exchange frames with each other.
// - unicast map enabled with all-zero map drops the missed frame.
//
// The implementer's own choice: the strobed register port.
module sfp_regs
  import sfp_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  input  wire logic        FRAME_REQ,
  input  wire logic [3:0]  FRAME_SRC,
  input  wire logic        FRAME_MISS,
  input  wire logic        FRAME_MCAST,
  input  wire logic        FRAME_CRC_OK,
  input  wire logic [15:0] FRAME_LEN_TYPE,
  input  wire logic [15:0] FRAME_DATA_LEN,
  input  wire logic [8:0]  FRAME_HIT_MAP,
  output logic             FRAME_DONE,
  output logic             FRAME_DROP,
  output logic      [8:0]  FRAME_DEST,
  output logic             FRAME_KEEP_FORMAT
);
  sfp_if cfg_bus ();
  logic [7:0] port_forward_control;
  logic [8:0] preserve_ingress_format;
  logic [8:0] protected_port_select;
  logic [8:0] unicast_miss_forward_map;
  logic [8:0] multicast_miss_map;
  logic [7:0] next_rdata;

  // forward control: reserved bits and scheme bit hold their defaults
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      port_forward_control <= SFP_FWD_CTRL_RESET;
    else if (WR && ADDR == SFP_ADDR_FWD_CTRL)
      port_forward_control <= (WDATA & SFP_FWD_CTRL_WMASK) | SFP_FWD_CTRL_RESET;
  end

  // per port fields, low byte carries ports 5..0, high byte bit 0 is port 8
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      preserve_ingress_format  <= SFP_PORT_RESET;
      protected_port_select    <= SFP_PORT_RESET;
      unicast_miss_forward_map <= SFP_PORT_RESET;
      multicast_miss_map       <= SFP_PORT_RESET;
    end
    else if (WR)
      case (ADDR)
        SFP_ADDR_PRESERVE_L: preserve_ingress_format[5:0] <= WDATA[5:0];
        SFP_ADDR_PRESERVE_H: preserve_ingress_format[8] <= WDATA[0];
        SFP_ADDR_PROTECT_L:  protected_port_select[5:0] <= WDATA[5:0];
        SFP_ADDR_PROTECT_H:  protected_port_select[8] <= WDATA[0];
        SFP_ADDR_UNI_MAP_L:  unicast_miss_forward_map[5:0] <= WDATA[5:0];
        SFP_ADDR_UNI_MAP_H:  unicast_miss_forward_map[8] <= WDATA[0];
        SFP_ADDR_MC_MAP_L:   multicast_miss_map[5:0] <= WDATA[5:0];
        SFP_ADDR_MC_MAP_H:   multicast_miss_map[8] <= WDATA[0];
        default:             ;
      endcase
  end

  // read mux, reserved bits and unmapped addresses read zero
  always_comb
  begin
    case (ADDR)
      SFP_ADDR_FWD_CTRL:   next_rdata = port_forward_control;
      SFP_ADDR_PRESERVE_L: next_rdata = {2'b00, preserve_ingress_format[5:0]};
      SFP_ADDR_PRESERVE_H: next_rdata = {7'h00, preserve_ingress_format[8]};
      SFP_ADDR_PROTECT_L:  next_rdata = {2'b00, protected_port_select[5:0]};
      SFP_ADDR_PROTECT_H:  next_rdata = {7'h00, protected_port_select[8]};
      SFP_ADDR_UNI_MAP_L:  next_rdata = {2'b00, unicast_miss_forward_map[5:0]};
      SFP_ADDR_UNI_MAP_H:  next_rdata = {7'h00, unicast_miss_forward_map[8]};
      SFP_ADDR_MC_MAP_L:   next_rdata = {2'b00, multicast_miss_map[5:0]};
      SFP_ADDR_MC_MAP_H:   next_rdata = {7'h00, multicast_miss_map[8]};
      default:             next_rdata = 8'h00;
    endcase
  end

  // read data stands one cycle after the read strobe only
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= next_rdata;
    else
      RDATA <= 8'h00;
  end

  // live settings to the judge
  assign cfg_bus.mc_use_map    = port_forward_control[SFP_BIT_MC_MAP];
  assign cfg_bus.uc_use_map    = port_forward_control[SFP_BIT_UC_MAP];
  assign cfg_bus.in_range_drop = port_forward_control[SFP_BIT_IN_RANGE];
  assign cfg_bus.gap_drop      = port_forward_control[SFP_BIT_GAP];
  assign cfg_bus.preserve      = preserve_ingress_format;
  assign cfg_bus.protect       = protected_port_select;
  assign cfg_bus.uni_map       = unicast_miss_forward_map;
  assign cfg_bus.mc_map        = multicast_miss_map;

  // frame decision engine
  sfp_judge u_judge
  (
    .clock       (CLOCK),
    .rstn        (RSTN),
    .cfg         (cfg_bus),
    .req         (FRAME_REQ),
    .src         (FRAME_SRC),
    .miss        (FRAME_MISS),
    .mcast       (FRAME_MCAST),
    .crc_ok      (FRAME_CRC_OK),
    .len_type    (FRAME_LEN_TYPE),
    .data_len    (FRAME_DATA_LEN),
    .hit_map     (FRAME_HIT_MAP),
    .done        (FRAME_DONE),
    .drop        (FRAME_DROP),
    .dest        (FRAME_DEST),
    .keep_format (FRAME_KEEP_FORMAT)
  );

  // checks on the bank and the judge
  a_scheme_stays_one: assert property (@(posedge CLOCK) disable iff (!RSTN)
    port_forward_control[SFP_BIT_GRP_SCHEME]) else $error("scheme bit cleared");
  a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
    port_forward_control[5:3] == 3'b000) else $error("reserved bits set");
  a_read_one_cycle: assert property (@(posedge CLOCK) disable iff (!RSTN)
    !$past(RD) |-> RDATA == 8'h00) else $error("read data outside slot");
  a_done_two_late: assert property (@(posedge CLOCK) disable iff (!RSTN)
    FRAME_REQ && !FRAME_DONE && u_judge.state == SFP_IDLE |-> ##2 FRAME_DONE)
    else $error("answer late");
  a_no_self_fwd: assert property (@(posedge CLOCK) disable iff (!RSTN)
    FRAME_DONE && $past(FRAME_SRC, 2) < 4'd9 |-> !FRAME_DEST[$past(FRAME_SRC, 2)])
    else $error("frame sent back to source");
  a_protect_iso: assert property (@(posedge CLOCK) disable iff (!RSTN)
    FRAME_DONE && $past(FRAME_SRC, 2) < 4'd9
    && protected_port_select[$past(FRAME_SRC, 2)] |-> (FRAME_DEST & protected_port_select) == 0)
    else $error("protected ports exchanged");
  a_empty_drops: assert property (@(posedge CLOCK) disable iff (!RSTN)
    FRAME_DONE && FRAME_DEST == 9'h000 |-> FRAME_DROP) else $error("empty set kept");
  a_gap_drop: assert property (@(posedge CLOCK) disable iff (!RSTN)
    u_judge.state == SFP_JUDGE && cfg_bus.gap_drop && u_judge.gap_err |=> FRAME_DROP)
    else $error("gap frame kept");
  c_frame_drop: cover property (@(posedge CLOCK) FRAME_DONE && FRAME_DROP);
  c_frame_pass: cover property (@(posedge CLOCK) FRAME_DONE && !FRAME_DROP);
  c_reg_read: cover property (@(posedge CLOCK) RD ##1 RDATA != 8'h00);
endmodule

//--- testbench/sfp_regs_test.sv
// self-checking bench for the forward policy register bank and its frame judge
module sfp_regs_test
  import sfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rstn, wr, rd, req, miss, mcast, crc, rd_seen;
  logic [7:0]  addr, wdata, rdata;
  logic [3:0]  src;
  logic [15:0] lt, dl;
  logic [8:0]  hit, dest, pres, prot, umap, mmap;
  logic        done, drop, keep;
  logic [7:0]  ctrl;
  logic [31:0] seed;
  logic [7:0]  rd_q[$];
  logic [10:0] fr_q[$];
  int          fails, cmp_count;
  logic [7:0]  addrs[12] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h32, 8'h33, 8'h34,
                             8'h35, 8'h20, 8'h26, 8'h36};
  logic [3:0]  srcs[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
  logic [15:0] lens[12] = '{16'h_0000, 16'h_002d, 16'h_002e, 16'h_002f, 16'h_0064, 16'h_05db,
                            16'h_05dc, 16'h_05dd, 16'h_05ff, 16'h_0600, 16'h_0601, 16'h_0800};
  sfp_regs i_sfp_regs (.CLOCK(clock), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .FRAME_REQ(req), .FRAME_SRC(src), .FRAME_MISS(miss),
    .FRAME_MCAST(mcast), .FRAME_CRC_OK(crc), .FRAME_LEN_TYPE(lt), .FRAME_DATA_LEN(dl),
    .FRAME_HIT_MAP(hit), .FRAME_DONE(done), .FRAME_DROP(drop), .FRAME_DEST(dest),
    .FRAME_KEEP_FORMAT(keep));
  // clock of 50 ns period
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // xorshift source of random stimulus
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // merge one byte into a 9-bit port field
  function automatic logic [8:0] upd(logic [8:0] old, logic hi, logic [7:0] d);
    return (hi ? {d[0], old[7:0]} : {old[8], d}) & SFP_PORT_MASK;
  endfunction
  // expected read value from the shadow copy
  function automatic logic [7:0] exp_rd(logic [7:0] a);
    case (a)
      SFP_ADDR_FWD_CTRL:   return ctrl;
      SFP_ADDR_PRESERVE_L: return pres[7:0];
      SFP_ADDR_PRESERVE_H: return {7'h_00, pres[8]};
      SFP_ADDR_PROTECT_L:  return prot[7:0];
      SFP_ADDR_PROTECT_H:  return {7'h_00, prot[8]};
      SFP_ADDR_UNI_MAP_L:  return umap[7:0];
      SFP_ADDR_UNI_MAP_H:  return {7'h_00, umap[8]};
      SFP_ADDR_MC_MAP_L:   return mmap[7:0];
      SFP_ADDR_MC_MAP_H:   return {7'h_00, mmap[8]};
      default:             return 8'h_00;
    endcase
  endfunction
  // legal write data: reserved bits at default, scheme bit kept at one
  function automatic logic [7:0] legal(logic [7:0] a, logic [7:0] r);
    if (a == SFP_ADDR_FWD_CTRL)
      return (r & SFP_FWD_CTRL_WMASK) | SFP_FWD_CTRL_RESET;
    return a[0] ? (r & 8'h_01) : (r & 8'h_3f);
  endfunction
  // register write, shadow updated alongside
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    case (a)
      SFP_ADDR_FWD_CTRL: ctrl = (d & SFP_FWD_CTRL_WMASK) | SFP_FWD_CTRL_RESET;
      SFP_ADDR_PRESERVE_L, SFP_ADDR_PRESERVE_H: pres = upd(pres, a[0], d);
      SFP_ADDR_PROTECT_L, SFP_ADDR_PROTECT_H: prot = upd(prot, a[0], d);
      SFP_ADDR_UNI_MAP_L, SFP_ADDR_UNI_MAP_H: umap = upd(umap, a[0], d);
      SFP_ADDR_MC_MAP_L, SFP_ADDR_MC_MAP_H: mmap = upd(mmap, a[0], d);
      default: ;
    endcase
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // register read, expected value noted for the monitor
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    rd_q.push_back(exp_rd(a));
    @(posedge clock);
    rd <= 1'b0;
  endtask
  // one random frame; twice means a second request while busy, which must be ignored
  task automatic frame(input logic twice);
    logic [31:0] r;
    logic [8:0]  sb, d;
    logic        err, dr;
    r = xorshift();
    @(posedge clock);
    req <= 1'b1;
    src <= srcs[r[2:0] % 7];
    miss <= r[3];
    mcast <= r[4];
    crc <= r[5] | r[6];
    hit <= r[20:12] & SFP_PORT_MASK;
    lt <= lens[r[10:7] % 12];
    case (r[23:21] % 5)
      0: dl <= lens[r[10:7] % 12];
      1: dl <= lens[r[10:7] % 12] + 16'h_0001;
      2: dl <= SFP_LEN_MIN;
      3: dl <= SFP_LEN_MIN + 16'h_0001;
      default: dl <= 16'h_0014;
    endcase
    #1;
    err = crc && ((ctrl[SFP_BIT_IN_RANGE] && ((lt >= SFP_LEN_MIN && lt <= SFP_LEN_MAX && lt != dl)
          || (lt < SFP_LEN_MIN && dl > SFP_LEN_MIN)))
          || (ctrl[SFP_BIT_GAP] && lt > SFP_LEN_MAX && lt < SFP_TYPE_MIN));
    sb = 9'h_001 << src;
    if (!miss)
      d = hit;
    else if (mcast)
      d = ctrl[SFP_BIT_MC_MAP] ? mmap : (SFP_PORT_MASK & ~sb);
    else
      d = ctrl[SFP_BIT_UC_MAP] ? umap : (SFP_PORT_MASK & ~sb);
    if ((prot & sb) != 9'h_000)
      d = d & ~prot;
    d = d & ~sb;
    dr = err || (d == 9'h_000);
    fr_q.push_back({dr, dr ? 9'h_000 : d, pres[src]});
    @(posedge clock);
    req <= twice;
    @(posedge clock);
    req <= 1'b0;
  endtask
  // compare one read result
  task automatic cmp_rd(input logic [7:0] got);
    logic [7:0] e;
    e = (rd_q.size() > 0) ? rd_q.pop_front() : ~got;
    cmp_count++;
    if (got !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  // compare one frame verdict, destination only for a forwarded frame
  task automatic cmp_frame(input logic [10:0] got);
    logic [10:0] e;
    e = (fr_q.size() > 0) ? fr_q.pop_front() : ~got;
    cmp_count++;
    if (got !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  // monitor: read data stands the cycle after the strobe, verdict with the done pulse
  always @(posedge clock)
  begin
    if (rd_seen === 1'b1) cmp_rd(rdata);
    if (done === 1'b1) cmp_frame({drop, (drop === 1'b1) ? 9'h_000 : dest, keep});
    rd_seen = rd;
  end
  // verdict and end of run
  task automatic final_report();
    if (rd_q.size() + fr_q.size() > 0) fails++;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    final_report();
  end
  // main sequence
  initial
  begin
    {rstn, wr, rd, req, miss, mcast, crc, rd_seen} = 8'h_00;
    {addr, wdata, src, lt, dl, hit} = 61'h0;
    {fails, cmp_count} = 0;
    seed = 32'h_0000_ce01;
    {ctrl, pres, prot, umap, mmap} = {SFP_FWD_CTRL_RESET, 36'h0};
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    foreach (addrs[i]) rd_reg(addrs[i]);
    $display("test reset values done");
    foreach (addrs[i]) wr_reg(addrs[i], legal(addrs[i], xorshift()));
    foreach (addrs[i]) rd_reg(addrs[i]);
    $display("test register access done");
    for (int k = 0; k < 16; k++)
    begin
      wr_reg(SFP_ADDR_FWD_CTRL, {k[3], k[2], 3'b000, k[1], k[0], 1'b1});
      for (int i = 1; i < 9; i++)
        wr_reg(addrs[i], (i == 5 || i == 6) && k % 4 == 0 ? 8'h_00 : legal(addrs[i], xorshift()));
      repeat (12) frame(xorshift() % 4 == 0);
      rd_reg(SFP_ADDR_FWD_CTRL);
    end
    $display("test frame judging done");
    repeat (6) @(posedge clock);
    final_report();
  end
endmodule
